// ### shared/bcs_pkg.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Shared constants for the bus cycle address and status outputs
package bcs_pkg;
  // Bus cycle status codes
  localparam logic [2:0] BCS_ST_INTA    = 3'h0;  // Interrupt acknowledge
  localparam logic [2:0] BCS_ST_IORD    = 3'h1;  // I/O read
  localparam logic [2:0] BCS_ST_IOWR    = 3'h2;  // I/O write
  localparam logic [2:0] BCS_ST_HALT    = 3'h3;  // Halt
  localparam logic [2:0] BCS_ST_FETCH   = 3'h4;  // Instruction fetch
  localparam logic [2:0] BCS_ST_MEMRD   = 3'h5;  // Memory read
  localparam logic [2:0] BCS_ST_MEMWR   = 3'h6;  // Memory write
  localparam logic [2:0] BCS_ST_PASSIVE = 3'h7;  // No bus activity
  // Values after reset
  localparam logic [19:0] BCS_ADDR_RST  = 20'h00000;  // Captured address
  localparam logic [2:0]  BCS_UPPER_RST = 3'h0;       // Upper address pins
  localparam logic        BCS_ORIG_RST  = 1'h0;       // Cycle origin
  localparam logic        BCS_UBE_RST   = 1'h1;       // Upper byte enable, idle high
  localparam logic        BCS_OE_RST    = 1'h1;       // Floating during reset
  // Lowest address bit on the middle pins, then on the upper pins
  localparam int          BCS_MID_LSB   = 8;
  localparam int          BCS_UP_LSB    = 16;
  // Phase sequencer states, one-hot
  typedef enum logic [2:0] {
    BCS_IDLE = 3'b001,
    BCS_ADDR = 3'b010,
    BCS_DATA = 3'b100
  } bcs_state_t;
endpackage : bcs_pkg
`default_nettype wire

// ### shared/bcs_phase_if.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Phase events from the sequencer to the pin drivers
interface bcs_phase_if;
  logic go_addr;  // Cycle starts, address phase next
  logic go_data;  // Address phase ends, data phase next
  logic go_idle;  // Data phase ends, bus goes passive
  logic addr_ph;  // Address phase is under way
  logic data_ph;  // Data phase is under way
  logic busy;     // Any phase is under way
  modport seq (output go_addr, go_data, go_idle, addr_ph, data_ph, busy);
  modport drv (input  go_addr, go_data, go_idle, addr_ph, data_ph, busy);
endinterface : bcs_phase_if
`default_nettype wire

// ### core/bcs_phase_seq.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Address/data phase sequencer
module bcs_phase_seq
  import bcs_pkg::*;
(
  input  wire logic   clock,       // System clock
  input  wire logic   rstn,        // Synchronous reset, active low
  input  wire logic   cyc_start,   // Request a new bus cycle
  input  wire logic   cyc_done,    // Ends the data phase
  input  wire logic   bus_hold,    // Bus granted to another master
  input  wire logic   powerdown,   // Powerdown mode
  output logic        cyc_ready,   // A start would be taken now
  bcs_phase_if.seq    ph           // Phase events
);
  import bcs_pkg::*;

  bcs_state_t state_r;   // Current phase
  bcs_state_t state_nxt; // Next phase
  logic       frozen;    // No new cycle may start

  assign frozen    = bus_hold | powerdown;
  assign cyc_ready = (state_r == BCS_IDLE) & ~frozen;

  //////////////////////////////////////////////////////////////////////////////
  // Next phase and transition events
  always_comb
  begin
    state_nxt  = state_r;
    ph.go_addr = 1'b0;
    ph.go_data = 1'b0;
    ph.go_idle = 1'b0;
    case (state_r)
      BCS_IDLE:
      begin
        // Start only while the bus is ours and awake
        if (cyc_start && !frozen)
        begin
          state_nxt  = BCS_ADDR;
          ph.go_addr = 1'b1;
        end
      end
      BCS_ADDR:
      begin
        // Address phase lasts one clock unless powerdown holds it
        if (!powerdown)
        begin
          state_nxt  = BCS_DATA;
          ph.go_data = 1'b1;
        end
      end
      BCS_DATA:
      begin
        // Data phase lasts until the cycle is done
        if (cyc_done && !powerdown)
        begin
          state_nxt  = BCS_IDLE;
          ph.go_idle = 1'b1;
        end
      end
      default:
      begin
        state_nxt = BCS_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Phase register
  always_ff @(posedge clock)
  begin
    if (!rstn)
      state_r <= BCS_IDLE;
    else
      state_r <= state_nxt;
  end

  assign ph.addr_ph = (state_r == BCS_ADDR);
  assign ph.data_ph = (state_r == BCS_DATA);
  assign ph.busy    = (state_r != BCS_IDLE);
endmodule : bcs_phase_seq
`default_nettype wire

// ### core/bcs_outputs.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Address phase shows address bits 16-19
// - Data phase drives bits 18-16 low
// - Data phase top pin shows cycle origin
// - Status code names cycle; 111 passive
// - Latch strobe pulses during address phase
// - Queue mode puts queue low bit on strobe
// - Upper byte enable low for upper data
// - Outputs float in hold and reset
// - Powerdown keeps address, status driven high
// - Latch strobe low in hold, reset, powerdown
module bcs_outputs
  import bcs_pkg::*;
#(
  parameter logic NARROW_BUS = 1'b0  // 1: 8-bit bus variant
)
(
  input  wire logic        clock,                     // System clock
  input  wire logic        rstn,                      // Synchronous reset, active low
  input  wire logic        cyc_start,                 // Request a bus cycle
  input  wire logic [2:0]  cyc_status,                // Status code of the request
  input  wire logic [19:0] cyc_addr,                  // Address of the request
  input  wire logic        cyc_dma,                   // Cycle started by DMA
  input  wire logic        cyc_refresh,               // Refresh cycle
  input  wire logic        cyc_upper,                 // Cycle uses upper data byte
  input  wire logic        cyc_done,                  // Ends the data phase
  output logic             cyc_ready,                 // Request would be taken
  input  wire logic        bus_hold,                  // Bus granted away
  input  wire logic        powerdown,                 // Powerdown mode
  input  wire logic        queue_state_mode_select_n, // Pin, low selects queue mode
  input  wire logic        queue_state_low_bit,       // Queue status, low bit
  input  wire logic        queue_state_high_bit,      // Queue status, high bit
  output logic             queue_state_high_pin,      // High bit toward write pin
  output logic             top_address_origin_pin,    // Bit 19 or origin flag
  output logic [2:0]       upper_address_bits,        // Bits 18-16
  output logic [7:0]       middle_address_bits,       // Bits 15-8, narrow bus
  output logic [2:0]       bus_cycle_status_code,     // Bus cycle status
  output logic             latch_strobe_queue_pin,    // Latch strobe or queue bit
  output logic             upper_byte_enable_n,       // Upper byte enable / refresh
  output logic             pins_oe_n                  // Low while pins are driven
);
  import bcs_pkg::*;

  bcs_phase_if ph ();  // Phase events

  logic [2:0] top_r;    // Pins 18-16 register
  logic       origin_r; // Captured origin flag
  logic [7:0] mid_r;    // Middle address register
  logic [2:0] stat_r;   // Status register
  logic       strobe_r; // Latch strobe pin register
  logic       ube_r;    // Upper byte enable register
  logic       pin19_r;  // Top pin register
  logic       oe_n_r;   // Output enable register
  logic       qhi_r;    // Queue high bit register
  logic       qsel_s1;  // Queue mode synchroniser, first stage
  logic       qsel_s2;  // Queue mode synchroniser, second stage
  logic       qmode;    // Queue status mode active

  //////////////////////////////////////////////////////////////////////////////
  // Phase sequencer
  bcs_phase_seq u_seq (
    .clock     (clock),
    .rstn      (rstn),
    .cyc_start (cyc_start),
    .cyc_done  (cyc_done),
    .bus_hold  (bus_hold),
    .powerdown (powerdown),
    .cyc_ready (cyc_ready),
    .ph        (ph)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Queue mode pin passes two flops
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      qsel_s1 <= 1'b1;
      qsel_s2 <= 1'b1;
    end
    else
    begin
      qsel_s1 <= queue_state_mode_select_n;
      qsel_s2 <= qsel_s1;
    end
  end
  assign qmode = ~qsel_s2;

  //////////////////////////////////////////////////////////////////////////////
  // Upper address pins and origin flag
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      top_r    <= BCS_UPPER_RST;
      pin19_r  <= BCS_ORIG_RST;
      origin_r <= BCS_ORIG_RST;
    end
    else if (ph.go_addr)
    begin
      // Address bits 19-16 for the outside latches
      pin19_r  <= cyc_addr[BCS_UP_LSB+3];
      top_r    <= cyc_addr[BCS_UP_LSB+2:BCS_UP_LSB];
      origin_r <= cyc_dma | cyc_refresh;
    end
    else if (ph.go_data)
    begin
      top_r   <= BCS_UPPER_RST;
      pin19_r <= origin_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Middle address pins hold through both phases
  always_ff @(posedge clock)
  begin
    if (!rstn)
      mid_r <= BCS_ADDR_RST[BCS_MID_LSB+7:BCS_MID_LSB];
    else if (ph.go_addr)
      mid_r <= cyc_addr[BCS_MID_LSB+7:BCS_MID_LSB];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status code
  always_ff @(posedge clock)
  begin
    if (!rstn)
      stat_r <= BCS_ST_PASSIVE;
    else if (powerdown)
      stat_r <= BCS_ST_PASSIVE;
    else if (ph.go_addr)
      stat_r <= cyc_status;
    else if (ph.go_idle)
      stat_r <= BCS_ST_PASSIVE;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Upper byte enable, or refresh flag on the narrow bus
  always_ff @(posedge clock)
  begin
    if (!rstn)
      ube_r <= BCS_UBE_RST;
    else if (ph.go_addr)
      ube_r <= NARROW_BUS ? ~cyc_refresh : ~cyc_upper;
    else if (ph.go_idle)
      ube_r <= BCS_UBE_RST;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Latch strobe or queue low bit, low in reset, hold and powerdown
  always_ff @(posedge clock)
  begin
    if (!rstn || bus_hold || powerdown)
    begin
      strobe_r <= 1'b0;
      qhi_r    <= 1'b0;
    end
    else if (qmode)
    begin
      strobe_r <= queue_state_low_bit;
      qhi_r    <= queue_state_high_bit;
    end
    else
    begin
      strobe_r <= ph.go_addr;
      qhi_r    <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Float in hold and reset
  always_ff @(posedge clock)
  begin
    if (!rstn)
      oe_n_r <= BCS_OE_RST;
    else
      oe_n_r <= bus_hold;
  end

  assign top_address_origin_pin = pin19_r;
  assign upper_address_bits     = top_r;
  assign middle_address_bits    = mid_r;
  assign bus_cycle_status_code  = stat_r;
  assign latch_strobe_queue_pin = strobe_r;
  assign upper_byte_enable_n    = ube_r;
  assign pins_oe_n              = oe_n_r;
  assign queue_state_high_pin   = qhi_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_addr_upper;
    ph.go_addr |=> {top_address_origin_pin, upper_address_bits} == $past(cyc_addr[19:16]);
  endproperty
  a_addr_upper: assert property (p_addr_upper) else $error("upper address wrong");

  property p_data_low;
    ph.go_data |=> upper_address_bits == 3'h0;
  endproperty
  a_data_low: assert property (p_data_low) else $error("upper bits not low");

  // Middle bits load at the start edge only, so no edge inside the cycle may move them
  property p_mid_hold;
    ph.addr_ph || (ph.data_ph && !ph.go_idle) |=> $stable(middle_address_bits);
  endproperty
  a_mid_hold: assert property (p_mid_hold) else $error("middle address moved");

  property p_origin;
    ph.go_addr ##1 ph.go_data |=>
      top_address_origin_pin == $past(cyc_dma | cyc_refresh, 2);
  endproperty
  a_origin: assert property (p_origin) else $error("origin flag wrong");

  property p_status;
    ph.go_addr && !powerdown |=> bus_cycle_status_code == $past(cyc_status);
  endproperty
  a_status: assert property (p_status) else $error("status code wrong");

  property p_passive;
    ph.go_idle |=> bus_cycle_status_code == 3'h7;
  endproperty
  a_passive: assert property (p_passive) else $error("status not passive");

  property p_strobe;
    ph.go_addr && !qmode |=> latch_strobe_queue_pin ##1 !latch_strobe_queue_pin;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe pulse wrong");

  property p_queue;
    qmode && !bus_hold && !powerdown |=>
      latch_strobe_queue_pin == $past(queue_state_low_bit);
  endproperty
  a_queue: assert property (p_queue) else $error("queue bit wrong");

  property p_ube;
    ph.go_addr && !NARROW_BUS |=> upper_byte_enable_n == !$past(cyc_upper);
  endproperty
  a_ube: assert property (p_ube) else $error("byte enable wrong");

  property p_float;
    bus_hold |=> pins_oe_n;
  endproperty
  a_float: assert property (p_float) else $error("pins not floated");

  property p_pd;
    powerdown && $past(powerdown) |=> bus_cycle_status_code == 3'h7
      && $stable(upper_address_bits) && $stable(upper_byte_enable_n);
  endproperty
  a_pd: assert property (p_pd) else $error("powerdown pins wrong");

  property p_strobe_low;
    bus_hold || powerdown |=> !latch_strobe_queue_pin;
  endproperty
  a_strobe_low: assert property (p_strobe_low) else $error("strobe not low");

  c_cycle: cover property (ph.go_addr ##1 ph.go_data ##[1:8] ph.go_idle);
  c_hold:  cover property (ph.busy ##1 bus_hold);
  c_queue: cover property (qmode && queue_state_low_bit);
  c_pd:    cover property (powerdown ##1 powerdown);
endmodule : bcs_outputs
`default_nettype wire

// ### dv/bcs_latch_model.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Outside address latch and cycle decoder seen from the far side of the pins
module bcs_latch_model
(
  input  wire logic        clock,      // System clock
  input  wire logic        strobe,     // Address latch strobe
  input  wire logic        pin_top,    // Bit 19 or cycle origin
  input  wire logic [2:0]  pin_upper,  // Bits 18-16
  input  wire logic [7:0]  pin_mid,    // Bits 15-8
  input  wire logic [2:0]  status,     // Bus cycle status code
  output logic      [11:0] held_addr,  // Captured bits 19-8
  output logic      [7:0]  access_cnt  // Accesses begun by the decoder
);
  timeunit 1ns;
  timeprecision 1ps;
  logic passive_r;  // Status was passive on the last edge
  initial
  begin
    held_addr  = 12'hFFF;
    access_cnt = 8'h00;
    passive_r  = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Latch follows the pins while strobe is high and holds once it falls
  always @(posedge clock)
  begin
    if (strobe === 1'b1)
    begin
      held_addr <= {pin_top, pin_upper, pin_mid};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // A new access starts only where a real code follows the passive code
  always @(posedge clock)
  begin
    passive_r <= (status === 3'h7);
    if (passive_r && (status inside {[3'h0:3'h6]}))
    begin
      access_cnt <= access_cnt + 8'h01;
    end
  end
endmodule : bcs_latch_model
`default_nettype wire

// ### dv/testbench.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the bus cycle address and status outputs
module testbench
  import bcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn, cyc_start, cyc_dma, cyc_refresh, cyc_upper, cyc_done;
  logic bus_hold, powerdown, qsel_n, q_low, q_high;
  logic [2:0]  cyc_status;
  logic [19:0] cyc_addr;
  logic cyc_ready, q_high_pin, top_pin, strobe, ube_n, oe_n;
  logic [2:0]  upper, status;
  logic [7:0]  middle, access_cnt;
  logic [11:0] held_addr;
  int mismatches, checks_done, cycles;
  ////////////////////////////////////////////////////////////////////////////////
  // Design and far-side model
  bcs_outputs #(.NARROW_BUS(1'b0)) u_bcs_outputs (
    .clock(clock), .rstn(rstn), .cyc_start(cyc_start), .cyc_status(cyc_status),
    .cyc_addr(cyc_addr), .cyc_dma(cyc_dma), .cyc_refresh(cyc_refresh),
    .cyc_upper(cyc_upper), .cyc_done(cyc_done), .cyc_ready(cyc_ready),
    .bus_hold(bus_hold), .powerdown(powerdown), .queue_state_mode_select_n(qsel_n),
    .queue_state_low_bit(q_low), .queue_state_high_bit(q_high),
    .queue_state_high_pin(q_high_pin), .top_address_origin_pin(top_pin),
    .upper_address_bits(upper), .middle_address_bits(middle),
    .bus_cycle_status_code(status), .latch_strobe_queue_pin(strobe),
    .upper_byte_enable_n(ube_n), .pins_oe_n(oe_n));
  bcs_latch_model u_bcs_latch_model (
    .clock(clock), .strobe(strobe), .pin_top(top_pin), .pin_upper(upper),
    .pin_mid(middle), .status(status), .held_addr(held_addr), .access_cnt(access_cnt));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles >= 2000)
    begin
      mismatches++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  // Reset for five cycles, pins float and strobe stays low
  task automatic do_reset;
    rstn = 1'b0;
    repeat (5) @(negedge clock);
    chk(oe_n, 1'b1, "float in reset");
    chk(strobe, 1'b0, "strobe in reset");
    chk(status, BCS_ST_PASSIVE, "status in reset");
    rstn = 1'b1;
    @(negedge clock);
  endtask : do_reset
  // Start a cycle at a falling edge once ready is seen
  task automatic launch(input logic [2:0] code, input logic [19:0] addr,
                        input logic dma, input logic refresh_indicator_n, input logic up);
    int n;
    n = 0;
    while (cyc_ready !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    chk(cyc_ready, 1'b1, "ready before start");
    {cyc_start, cyc_status, cyc_addr, cyc_dma, cyc_refresh, cyc_upper} =
      {1'b1, code, addr, dma, refresh_indicator_n, up};
    @(negedge clock);
    cyc_start = 1'b0;
  endtask : launch
  // Whole cycle with address phase, data phase and return to passive
  task automatic run_cycle(input logic [2:0] code, input logic [19:0] addr,
                           input logic dma, input logic refresh_indicator_n, input logic up);
    logic [7:0] acc;
    acc = access_cnt;
    launch(code, addr, dma, refresh_indicator_n, up);
    chk({top_pin, upper}, addr[19:16], "address phase top bits");
    chk(middle, addr[15:8], "address phase middle bits");
    chk(status, code, "status in address phase");
    chk(strobe, 1'b1, "strobe in address phase");
    chk(ube_n, !up, "upper byte enable");
    chk(oe_n, 1'b0, "pins driven");
    @(negedge clock);
    chk(upper, 3'h0, "data phase upper bits");
    chk(top_pin, dma | refresh_indicator_n, "cycle origin");
    chk(middle, addr[15:8], "data phase middle bits");
    chk(strobe, 1'b0, "strobe in data phase");
    chk(status, code, "status in data phase");
    chk(held_addr, addr[19:8], "latched address");
    chk(access_cnt, 8'(acc + 8'h01), "one access per cycle");
    cyc_done = 1'b1;
    @(negedge clock);
    cyc_done = 1'b0;
    chk(status, BCS_ST_PASSIVE, "passive after done");
    chk(ube_n, 1'b1, "upper byte enable idle");
  endtask : run_cycle
  // Bus granted away: pins float, strobe low, start refused
  task automatic hold_case;
    bus_hold = 1'b1;
    cyc_start = 1'b1;
    cyc_status = BCS_ST_MEMRD;
    @(negedge clock);
    chk(oe_n, 1'b1, "float in hold");
    chk(strobe, 1'b0, "strobe in hold");
    chk(cyc_ready, 1'b0, "no start in hold");
    repeat (2) @(negedge clock);
    bus_hold = 1'b0;
    cyc_start = 1'b0;
    @(negedge clock);
    chk(oe_n, 1'b0, "driven after hold");
    chk(status, BCS_ST_PASSIVE, "start refused in hold");
  endtask : hold_case
  // Powerdown in address phase: address kept, status high, then reset again
  task automatic pd_case;
    launch(BCS_ST_MEMWR, 20'hB6D29, 1'b0, 1'b0, 1'b1);
    powerdown = 1'b1;
    @(negedge clock);
    chk({top_pin, upper}, 4'hB, "address kept in powerdown");
    chk(ube_n, 1'b0, "enable kept in powerdown");
    chk(status, 3'h7, "status high in powerdown");
    chk(strobe, 1'b0, "strobe in powerdown");
    powerdown = 1'b0;
    do_reset();
  endtask : pd_case
  // Queue mode: strobe pin carries the low queue bit, still forced low in hold
  task automatic queue_case;
    qsel_n = 1'b0;
    repeat (4) @(negedge clock);
    {q_low, q_high} = 2'b11;
    @(negedge clock);
    chk(strobe, 1'b1, "queue low bit");
    chk(q_high_pin, 1'b1, "queue high bit");
    q_low = 1'b0;
    @(negedge clock);
    chk(strobe, 1'b0, "queue low bit clear");
    {q_low, bus_hold} = 2'b11;
    @(negedge clock);
    chk(strobe, 1'b0, "queue bit low in hold");
    {q_low, q_high, bus_hold, qsel_n} = 4'b0001;
    repeat (4) @(negedge clock);
  endtask : queue_case
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rstn, cyc_start, cyc_dma, cyc_refresh, cyc_upper, cyc_done} = 6'h00;
    {bus_hold, powerdown, q_low, q_high, cyc_status, cyc_addr} = 27'h0;
    qsel_n = 1'b1;
    @(negedge clock);
    do_reset();
    // Every non-passive code, back to back, both origins and byte enables
    for (int c = 0; c < 7; c++)
    begin
      run_cycle(3'(c), 20'(20'h1A5C3 + c * 20'h24F31), c[0], c[1] & ~c[0], c[1]);
    end
    hold_case();
    pd_case();
    run_cycle(BCS_ST_FETCH, 20'hFFFF0, 1'b0, 1'b1, 1'b0);
    queue_case();
    close_out();
  end
endmodule : testbench
`default_nettype wire
